// *** rtl/flash_map_pkg.sv ***
package flash_map_pkg;
  localparam int addr_w = 4;
  localparam logic [3:0] off_data_supv = 4'h0;
  localparam logic [3:0] off_prog_fetch = 4'h4;
  localparam logic [3:0] off_data_fetch = 4'h8;
  localparam logic [3:0] off_user_status = 4'hc;
  localparam logic [3:0] off_module_config = 4'h1;
  localparam int bit_buf_empty = 7;
  localparam int bit_cmd_done = 6;
  localparam int bit_prot_viol = 5;
  localparam int bit_acc_err = 4;
  localparam int bit_blank = 2;
  localparam int bit_lock = 0;
  localparam int bit_cbe_ie = 7;
  localparam int bit_cc_ie = 6;
  localparam logic [7:0] status_reset = 8'hc0;
  localparam logic [7:0] config_reset = 8'h01;
endpackage : flash_map_pkg

// *** rtl/flash_access_map_and_status.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_access_map_and_status (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [flash_map_pkg::addr_w-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // configuration fields: two bytes and one 32-bit word (cfg_prog_fetch)
  input wire logic [7:0] cfg_data_supv,
  input wire logic [31:0] cfg_prog_fetch,
  input wire logic [7:0] cfg_data_fetch,
  // command controller events
  input wire logic buffers_empty,
  input wire logic commands_done,
  input wire logic prot_hit,
  input wire logic illegal_access,
  input wire logic blank_found,
  // outputs
  output logic [7:0] data_flash_supervisor_map,
  output logic [31:0] program_flash_fetch_map,
  output logic [7:0] data_flash_fetch_map,
  output logic launch_allowed,
  output logic seq_abort,
  output logic buffer_empty_irq,
  output logic command_complete_irq
);
  import flash_map_pkg::*;

  logic [7:0] flash_module_config;
  logic buffer_empty_flag;
  logic command_complete_flag;
  logic protection_violation_flag;
  logic access_error_flag;
  logic blank_flag;
  logic in_reset;
  logic [7:0] flash_user_status;

  wire logic lock = flash_module_config[bit_lock];
  wire logic map_wr_ok = reg_wr && !lock;
  wire logic st_wr = reg_wr && (reg_addr == off_user_status);
  wire logic clr_be = st_wr && reg_wdata[bit_buf_empty];
  wire logic clr_pv = st_wr && reg_wdata[bit_prot_viol];
  wire logic clr_ae = st_wr && reg_wdata[bit_acc_err];
  wire logic clr_bl = st_wr && reg_wdata[bit_blank];
  wire logic cfg_wr = reg_wr && (reg_addr == off_module_config);
  wire logic be_taken = clr_be && launch_allowed && !buffers_empty;

  // in_reset marks the first cycle after release for loading maps
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_flash_supervisor_map <= '0;
    end else if (in_reset) begin
      data_flash_supervisor_map <= cfg_data_supv;
    end else if (map_wr_ok && reg_addr == off_data_supv) begin
      data_flash_supervisor_map <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      program_flash_fetch_map <= '0;
    end else if (in_reset) begin
      program_flash_fetch_map <= cfg_prog_fetch;
    end else if (map_wr_ok && reg_addr == off_prog_fetch) begin
      program_flash_fetch_map <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_flash_fetch_map <= '0;
    end else if (in_reset) begin
      data_flash_fetch_map <= cfg_data_fetch;
    end else if (map_wr_ok && reg_addr == off_data_fetch) begin
      data_flash_fetch_map <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flash_module_config <= config_reset;
    end else if (cfg_wr) begin
      flash_module_config <= reg_wdata[7:0];
    end
  end

  // set wins over clear on every flag
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      buffer_empty_flag <= status_reset[bit_buf_empty];
    end else if (buffers_empty) begin
      buffer_empty_flag <= 1'b1;
    end else if (be_taken) begin
      buffer_empty_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      command_complete_flag <= status_reset[bit_cmd_done];
    end else if (commands_done) begin
      command_complete_flag <= 1'b1;
    end else if (be_taken && buffer_empty_flag) begin
      command_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      protection_violation_flag <= status_reset[bit_prot_viol];
    end else if (prot_hit) begin
      protection_violation_flag <= 1'b1;
    end else if (clr_pv) begin
      protection_violation_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      access_error_flag <= status_reset[bit_acc_err];
    end else if (illegal_access) begin
      access_error_flag <= 1'b1;
    end else if (clr_ae) begin
      access_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      blank_flag <= status_reset[bit_blank];
    end else if (blank_found) begin
      blank_flag <= 1'b1;
    end else if (clr_bl) begin
      blank_flag <= 1'b0;
    end
  end

  always_comb begin
    flash_user_status = '0;
    flash_user_status[bit_buf_empty] = buffer_empty_flag;
    flash_user_status[bit_cmd_done] = command_complete_flag;
    flash_user_status[bit_prot_viol] = protection_violation_flag;
    flash_user_status[bit_acc_err] = access_error_flag;
    flash_user_status[bit_blank] = blank_flag;
  end

  assign launch_allowed =
    !protection_violation_flag && !access_error_flag;
  assign seq_abort = st_wr && !reg_wdata[bit_buf_empty];
  assign buffer_empty_irq =
    buffer_empty_flag && flash_module_config[bit_cbe_ie];
  assign command_complete_irq =
    command_complete_flag && flash_module_config[bit_cc_ie];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        off_data_supv: reg_rdata <= {24'h00_0000, data_flash_supervisor_map};
        off_prog_fetch: reg_rdata <= program_flash_fetch_map;
        off_data_fetch: reg_rdata <= {24'h00_0000, data_flash_fetch_map};
        off_user_status: reg_rdata <= {24'h00_0000, flash_user_status};
        off_module_config: reg_rdata <= {24'h00_0000, flash_module_config};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  a_locked_map_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && lock && !in_reset && reg_addr == off_prog_fetch
    |=> $stable(program_flash_fetch_map)
  ) else $error("locked map changed");

  a_locked_supv_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && lock && !in_reset && reg_addr == off_data_supv
    |=> $stable(data_flash_supervisor_map)
  ) else $error("locked supervisor map changed");

  a_locked_fetch_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && lock && !in_reset && reg_addr == off_data_fetch
    |=> $stable(data_flash_fetch_map)
  ) else $error("locked data fetch map changed");

  a_unlocked_map_wr: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && !lock && !in_reset && reg_addr == off_data_supv
    |=> data_flash_supervisor_map == $past(reg_wdata[7:0])
  ) else $error("map write lost");

  a_prog_map_wr: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && !lock && !in_reset && reg_addr == off_prog_fetch
    |=> program_flash_fetch_map == $past(reg_wdata)
  ) else $error("program fetch write lost");

  a_fetch_map_wr: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && !lock && !in_reset && reg_addr == off_data_fetch
    |=> data_flash_fetch_map == $past(reg_wdata[7:0])
  ) else $error("fetch write lost");

  a_reset_load: assert property (
    @(posedge mclk) disable iff (!nrst)
    nrst && in_reset
    |=> program_flash_fetch_map == $past(cfg_prog_fetch)
  ) else $error("no load");

  a_reset_supv_load: assert property (
    @(posedge mclk) disable iff (!nrst)
    nrst && in_reset
    |=> data_flash_supervisor_map == $past(cfg_data_supv)
  ) else $error("no supervisor map load");

  a_reset_fetch_load: assert property (
    @(posedge mclk) disable iff (!nrst)
    nrst && in_reset
    |=> data_flash_fetch_map == $past(cfg_data_fetch)
  ) else $error("no data fetch map load");

  a_supv_map_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == off_data_supv
    |=> reg_rdata == {24'h00_0000, $past(data_flash_supervisor_map)}
  ) else $error("supervisor map read wrong");

  a_prog_map_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == off_prog_fetch
    |=> reg_rdata == $past(program_flash_fetch_map)
  ) else $error("program fetch map read wrong");

  a_fetch_map_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == off_data_fetch
    |=> reg_rdata == {24'h00_0000, $past(data_flash_fetch_map)}
  ) else $error("data fetch map read wrong");

  a_status_rsvd: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == off_user_status
    |=> reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'b00
  ) else $error("reserved set");

  a_be_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    buffers_empty
    |=> buffer_empty_flag
  ) else $error("buffer empty not set");

  a_be_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    be_taken
    |=> !buffer_empty_flag
  ) else $error("buffer empty not cleared");

  a_be_abort_keeps: assert property (
    @(posedge mclk) disable iff (!nrst)
    seq_abort && buffer_empty_flag
    |=> buffer_empty_flag
  ) else $error("abort cleared");

  a_be_irq: assert property (
    @(posedge mclk) disable iff (!nrst)
    buffers_empty && flash_module_config[bit_cbe_ie] && !cfg_wr
    |=> buffer_empty_irq
  ) else $error("be irq");

  a_cc_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    commands_done
    |=> command_complete_flag
  ) else $error("command complete not set");

  a_cc_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    be_taken && buffer_empty_flag && !commands_done
    |=> !command_complete_flag
  ) else $error("command complete not cleared");

  a_cc_wr_ignored: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_wr && !reg_wdata[bit_buf_empty] && !commands_done
    |=> $stable(command_complete_flag)
  ) else $error("command complete written");

  a_cc_irq: assert property (
    @(posedge mclk) disable iff (!nrst)
    commands_done && flash_module_config[bit_cc_ie] && !cfg_wr
    |=> command_complete_irq
  ) else $error("cc irq");

  a_pv_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    prot_hit
    |=> protection_violation_flag
  ) else $error("protection_violation_flag not set");

  a_pv_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    clr_pv && !prot_hit
    |=> !protection_violation_flag
  ) else $error("protection_violation_flag stuck");

  a_pv_blocks_seq: assert property (
    @(posedge mclk) disable iff (!nrst)
    protection_violation_flag && buffer_empty_flag
    |=> buffer_empty_flag
  ) else $error("sequence started under protection_violation_flag");

  a_block_launch: assert property (
    @(posedge mclk) disable iff (!nrst)
    access_error_flag && buffer_empty_flag
    |=> buffer_empty_flag
  ) else $error("launch");

  a_ae_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    illegal_access
    |=> access_error_flag
  ) else $error("acc err not set");

  a_ae_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    clr_ae && !illegal_access
    |=> !access_error_flag
  ) else $error("acc err stuck");

  a_blank_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    blank_found
    |=> blank_flag
  ) else $error("blank not set");

  a_blank_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    clr_bl && !blank_found
    |=> !blank_flag
  ) else $error("blank stuck");

  c_locked_write: cover property (@(posedge mclk) reg_wr && lock);
  c_cmd_start: cover property (@(posedge mclk) clr_be && launch_allowed);
  c_set_clear_same: cover property (@(posedge mclk) illegal_access && clr_ae);
  c_be_irq_fire: cover property (@(posedge mclk) buffer_empty_irq);
  c_abort_seen: cover property (@(posedge mclk) seq_abort && buffer_empty_flag);
endmodule : flash_access_map_and_status
`default_nettype wire

// *** test/tb_flash_access_map_and_status.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_flash_access_map_and_status;
  import flash_map_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [addr_w-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [4:0] evt = '0;
  logic [7:0] c_sup;
  logic [31:0] c_pf;
  logic [7:0] c_df;
  logic [7:0] dsm, dfm;
  logic [31:0] pfm;
  logic la, abo, bi, ci, ab;
  logic [31:0] seed = 32'h0000_0061;
  logic [31:0] r;
  logic [31:0] m[3];
  logic [7:0] st = 8'hc0;
  logic [7:0] cf = 8'h01;
  int err_count = 0;
  int n_checks = 0;
  localparam logic [3:0] offs[3] = '{off_data_supv, off_prog_fetch,
    off_data_fetch};
  localparam logic [31:0] msk[3] = '{32'h0000_00ff, 32'hffff_ffff,
    32'h0000_00ff};
  localparam logic [7:0] sw[6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h00};
  // event k sets status bit eb[k]
  localparam int eb[5] = '{2, 4, 5, 6, 7};
  always #4 mclk = ~mclk;
  flash_access_map_and_status flash_access_map_and_status_i (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_data_supv(c_sup), .cfg_prog_fetch(c_pf), .cfg_data_fetch(c_df),
    .buffers_empty(evt[4]), .commands_done(evt[3]), .prot_hit(evt[2]),
    .illegal_access(evt[1]), .blank_found(evt[0]),
    .data_flash_supervisor_map(dsm), .program_flash_fetch_map(pfm),
    .data_flash_fetch_map(dfm), .launch_allowed(la), .seq_abort(abo),
    .buffer_empty_irq(bi), .command_complete_irq(ci));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // one-flag write: ones clear except at bit 6, buffer-empty clear refused on error flags
  function logic [7:0] st_wr(input logic [7:0] s, input logic [7:0] w);
    logic [7:0] n;
    n = s & ~(w & 8'h34);
    if (w[7] && s[7] && !s[5] && !s[4]) n[7:6] = 2'b00;
    return n;
  endfunction : st_wr
  task end_of_test();
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge mclk);
    ab = abo;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(nm, e, reg_rdata);
  endtask : rd
  task maps();
    for (int i = 0; i < 3; i++) begin
      rd(offs[i], m[i], "map read");
    end
    chk("supv map", m[0], {24'h0, dsm});
    chk("prog fetch map", m[1], pfm);
    chk("data fetch map", m[2], {24'h0, dfm});
  endtask : maps
  task flags();
    rd(off_user_status, {24'h0, st}, "status");
    chk("launch_allowed", 32'(!(st[5] || st[4])), 32'(la));
    chk("buffer_empty_irq", 32'(st[7] && cf[7]), 32'(bi));
    chk("command_complete_irq", 32'(st[6] && cf[6]), 32'(ci));
  endtask : flags
  // sel 0: controller event k, 1: status write sw[k], 2: irq enables
  task op(input int sel, input int k);
    if (sel == 0) begin
      @(posedge mclk);
      evt[k] <= 1'b1;
      @(posedge mclk);
      evt[k] <= 1'b0;
      st[eb[k]] = 1'b1;
    end else if (sel == 1) begin
      wr(off_user_status, {24'h0, sw[k]});
      chk("seq_abort", {31'h0, ~sw[k][7]}, {31'h0, ab});
      st = st_wr(st, sw[k]);
    end else begin
      cf = {k[1:0], 6'h01};
      wr(off_module_config, {24'h0, cf});
    end
    flags();
  endtask : op
  initial begin
    for (int i = 0; i < 3; i++) m[i] = xs() & msk[i];
    c_sup = m[0][7:0];
    c_pf = m[1];
    c_df = m[2][7:0];
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    maps();
    flags();
    for (int l = 0; l < 3; l++) begin
      r = xs();
      cf = {r[7:6], 5'h00, 1'(l != 1)};
      wr(off_module_config, {24'h0, cf});
      for (int i = 0; i < 3; i++) begin
        r = xs();
        wr(offs[i], r);
        if (!cf[0]) m[i] = r & msk[i];
      end
      maps();
    end
    rd(4'h2, 32'h0, "unmapped");
    op(2, 3);
    op(0, 2);
    op(1, 0);
    op(1, 2);
    op(0, 1);
    op(1, 0);
    op(1, 3);
    op(1, 0);
    op(0, 3);
    repeat (40) begin
      r = xs();
      op(r[1:0] == 2'd3 ? 2 : int'(r[0]), int'(r[7:4]) % (r[0] ? 6 : 5));
    end
    end_of_test();
  end
  initial begin
    #50000;
    err_count++;
    end_of_test();
  end
endmodule : tb_flash_access_map_and_status
`default_nettype wire
